// file: include/cct_pkg.sv
package cct_pkg;
   // register byte addresses on the bus
   localparam logic [11:0] SEL_OFF = 12'h086; // pointer select index; byte address is four times it
   localparam logic [11:0] SEL_ADDR = 12'h218; // 4 * 86h
   localparam logic [11:0] CLK_CTRL_ADDR = 12'h220;
   localparam logic [11:0] DPTR0_ADDR = 12'h224;
   localparam logic [11:0] SECONDARY_DATA_POINTER_ADDR = 12'h228;
   localparam logic [11:0] STAT_ADDR = 12'h22c;
   // field layout and reset values
   localparam int SEL_BIT = 0;
   localparam int STRETCH_LSB = 0;
   localparam int STRETCH_W = 3;
   localparam logic [2:0] STRETCH_RST = 3'h1;
   localparam logic SEL_RST = 1'b0;
   // timing counts: strobe widths in clocks, move base in machine cycles
   localparam logic [1:0] STATES_PER_CYCLE = 2'h3; // last state index of four
   localparam logic [4:0] STROBE_MIN = 5'h02;
   localparam logic [4:0] STROBE_STEP = 5'h04;
   localparam logic [3:0] MOVE_BASE = 4'h2;
   // machine cycle states, one-hot
   typedef enum logic [3:0]
   {
      ST_ONE = 4'h1,
      ST_TWO = 4'h2,
      ST_THREE = 4'h4,
      ST_FOUR = 4'h8
   } cct_state_t;
endpackage

// file: rtl/cct_core.sv
`timescale 1ns/1ps
module cct_core
   import cct_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // instruction execution side
   input wire logic [2:0] instr_cycles,
   input wire logic instr_start,
   input wire logic move_start,
   input wire logic move_write,
   input wire logic move_indirect,
   input wire logic [7:0] indirect_work_register,
   input wire logic [7:0] port2_latch,
   input wire logic [7:0] move_wdata,
   input wire logic sel_inc,
   output logic [3:0] state_onehot,
   output logic fetch_strobe,
   output logic instr_done,
   output logic busy,
   output logic [7:0] move_rdata,
   // external data bus
   output logic [15:0] ext_addr,
   output logic [7:0] ext_dout,
   output logic ext_doe,
   input wire logic [7:0] ext_din,
   output logic ext_rd_n,
   output logic ext_wr_n
);
   typedef struct packed
   {
      cct_state_t st;
      logic [3:0] cyc_left;
      logic in_move;
      logic mv_write;
      logic [4:0] strobe_left;
      logic strobe_on;
      logic sel;
      logic [2:0] stretch;
      logic [2:0] mv_stretch;
      logic [15:0] dptr0;
      logic [15:0] secondary_data_pointer;
      logic [15:0] addr;
      logic [7:0] dout;
      logic doe;
      logic [7:0] rdata;
      logic fetch;
      logic done;
      logic ph_act;
      logic ph_wr;
      logic [11:0] ph_addr;
      logic [31:0] hrdata;
   } cct_regs_t;

   cct_regs_t q, d;
   logic neg_phase_q;

   // strobe width in clocks for a stretch value
   function automatic logic [4:0] strobe_width(input logic [2:0] s);
      strobe_width = (s == 3'h0) ? STROBE_MIN : 5'(STROBE_STEP * 5'(s));
   endfunction

   // falling edge marks the middle of each state for the strobe edges
   always_ff @(negedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         neg_phase_q <= 1'b0;
      else
         neg_phase_q <= q.strobe_on;
   end

   always_comb
   begin
      d = q;
      d.fetch = 1'b0;
      d.done = 1'b0;
      // fixed four-state rotation
      unique case (q.st)
         ST_ONE: d.st = ST_TWO;
         ST_TWO: d.st = ST_THREE;
         ST_THREE: d.st = ST_FOUR;
         ST_FOUR: d.st = ST_ONE;
         default: d.st = ST_ONE;
      endcase
      // instruction length counted at the end of each cycle
      if (q.st == ST_FOUR)
      begin
         if (q.cyc_left > 4'h1)
         begin
            d.cyc_left = q.cyc_left - 4'h1;
            d.fetch = !q.in_move;
         end
         else
         begin
            // a finishing instruction hands over in the same edge, so no idle cycle is lost
            if (q.cyc_left == 4'h1)
            begin
               d.cyc_left = 4'h0;
               d.done = 1'b1;
               d.in_move = 1'b0;
               d.doe = 1'b0;
            end
            if (move_start)
            begin
               d.cyc_left = MOVE_BASE + 4'(q.stretch);
               d.mv_stretch = q.stretch; // later stretch writes must not bend a running move
               d.in_move = 1'b1;
               d.mv_write = move_write;
               d.fetch = 1'b1;
               if (move_indirect)
                  d.addr = {port2_latch, indirect_work_register};
               else
                  d.addr = q.sel ? q.secondary_data_pointer : q.dptr0;
               d.dout = move_wdata;
            end
            else if (instr_start)
            begin
               // lengths above five are clipped; zero treated as one
               d.cyc_left = (instr_cycles > 3'h5) ? 4'h5 :
                  ((instr_cycles == 3'h0) ? 4'h1 : 4'(instr_cycles));
               d.fetch = 1'b1;
            end
         end
      end
      // strobe starts in state two of the access cycle, held for its width
      if (q.in_move && q.st == ST_ONE && q.cyc_left == MOVE_BASE + 4'(q.mv_stretch) - 4'h1 && !q.strobe_on)
      begin
         d.strobe_on = 1'b1;
         d.strobe_left = strobe_width(q.mv_stretch);
         d.doe = q.mv_write;
      end
      else if (q.strobe_on)
      begin
         d.strobe_left = q.strobe_left - 5'h01;
         if (q.strobe_left == 5'h01)
         begin
            d.strobe_on = 1'b0;
            if (!q.mv_write)
               d.rdata = ext_din;
         end
      end
      if (sel_inc)
         d.sel = !q.sel;
      // bus data phase
      d.hrdata = 32'h0;
      if (q.ph_act && q.ph_wr)
      begin
         unique case (q.ph_addr)
            SEL_ADDR: d.sel = hwdata[SEL_BIT];
            CLK_CTRL_ADDR: d.stretch = hwdata[STRETCH_LSB +: STRETCH_W];
            DPTR0_ADDR: d.dptr0 = hwdata[15:0];
            SECONDARY_DATA_POINTER_ADDR: d.secondary_data_pointer = hwdata[15:0];
            default: ;
         endcase
      end
      // bus address phase, always ready
      d.ph_act = hsel && hready && htrans[1];
      d.ph_wr = hwrite;
      d.ph_addr = haddr[11:0];
      if (hsel && hready && htrans[1] && !hwrite)
      begin
         unique case (haddr[11:0])
            SEL_ADDR: d.hrdata = {31'h0, d.sel};
            CLK_CTRL_ADDR: d.hrdata = {29'h0, d.stretch};
            DPTR0_ADDR: d.hrdata = {16'h0, d.dptr0};
            SECONDARY_DATA_POINTER_ADDR: d.hrdata = {16'h0, d.secondary_data_pointer};
            STAT_ADDR: d.hrdata = {26'h0, q.strobe_on, q.in_move, q.st};
            default: d.hrdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q <= '0;
         q.st <= ST_ONE;
         q.sel <= SEL_RST;
         q.stretch <= STRETCH_RST;
      end
      else
         q <= d;
   end

   // outputs
   assign hrdata = q.hrdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign state_onehot = q.st;
   assign fetch_strobe = q.fetch;
   assign instr_done = q.done;
   assign busy = (q.cyc_left != 4'h0);
   assign move_rdata = q.rdata;
   assign ext_addr = q.addr;
   assign ext_dout = q.dout;
   assign ext_doe = q.doe;
   // strobes move on falling edges: address and data get half a clock of setup and hold, width unchanged
   assign ext_rd_n = !(neg_phase_q && !q.mv_write);
   assign ext_wr_n = !(neg_phase_q && q.mv_write);

   // a move taken at the end of state four, and its two address forms
   sequence move_go_s;
      q.st == ST_FOUR && q.cyc_left <= 4'h1 && move_start;
   endsequence
   sequence move_ptr_s;
      q.st == ST_FOUR && q.cyc_left <= 4'h1 && move_start && !move_indirect;
   endsequence
   sequence move_ind_s;
      q.st == ST_FOUR && q.cyc_left <= 4'h1 && move_start && move_indirect;
   endsequence
   // last clock of a strobe, when read data is taken
   sequence strobe_end_s;
      q.strobe_on && q.strobe_left == 5'h01;
   endsequence
   // the rest of one rotation after state one
   sequence rotation_s;
      q.st == ST_TWO ##1 q.st == ST_THREE ##1 q.st == ST_FOUR ##1 q.st == ST_ONE;
   endsequence

   // states rotate strictly
   state_rot_a: assert property (@(posedge hclk) disable iff (!hresetn)
      q.st == ST_ONE |=> rotation_s)
      else $error("state order broken");
   state_hot_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $onehot(state_onehot))
      else $error("state not one hot");
   done_st_a: assert property (@(posedge hclk) disable iff (!hresetn)
      instr_done |-> state_onehot == ST_ONE)
      else $error("completion off the cycle boundary");
   // pointer select register
   sel_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      hsel && hready && htrans[1] && !hwrite && haddr[11:0] == SEL_ADDR |=> hrdata[31:1] == 31'h0)
      else $error("select upper bits nonzero");
   sel_inc_a: assert property (@(posedge hclk) disable iff (!hresetn)
      sel_inc && !(q.ph_act && q.ph_wr) |=> q.sel != $past(q.sel))
      else $error("increment failed to toggle");
   // move address, move and instruction length
   ptr_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      move_ptr_s
      |=> ext_addr == ($past(q.sel) ? $past(q.secondary_data_pointer) : $past(q.dptr0)))
      else $error("pointer address wrong");
   ind_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      move_ind_s
      |=> ext_addr == {$past(port2_latch), $past(indirect_work_register)})
      else $error("indirect address wrong");
   move_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
      move_go_s |=> q.cyc_left == MOVE_BASE + 4'($past(q.stretch)))
      else $error("move length wrong");
   len_max_a: assert property (@(posedge hclk) disable iff (!hresetn)
      q.cyc_left <= 4'h9)
      else $error("length beyond nine cycles");
   instr_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
      q.st == ST_FOUR && q.cyc_left <= 4'h1 && !move_start && instr_start
      |=> q.cyc_left >= 4'h1 && q.cyc_left <= 4'h5)
      else $error("instruction length out of range");
   // strobe shape
   strobe_w_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(q.strobe_on) |-> q.strobe_left == strobe_width(q.mv_stretch))
      else $error("strobe width wrong");
   strb_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(q.strobe_on) |-> q.st == ST_TWO)
      else $error("strobe not in state two");
   strb_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
      strobe_end_s |=> !q.strobe_on)
      else $error("strobe overran its width");
   rd_take_a: assert property (@(posedge hclk) disable iff (!hresetn)
      q.strobe_on && q.strobe_left == 5'h01 && !q.mv_write |=> move_rdata == $past(ext_din))
      else $error("read byte not taken");
   strb_excl_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ext_rd_n || ext_wr_n)
      else $error("both strobes low");
   wr_data_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !ext_wr_n |-> ext_doe)
      else $error("write strobe without data");
   // fetch pacing
   one_fetch_a: assert property (@(posedge hclk) disable iff (!hresetn)
      fetch_strobe |=> !fetch_strobe [*3])
      else $error("two fetches in a cycle");
   fetch_st_a: assert property (@(posedge hclk) disable iff (!hresetn)
      fetch_strobe |-> state_onehot == ST_ONE)
      else $error("fetch off the cycle boundary");
endmodule // cct_core

// file: tb/cct_ext_mem.sv
`timescale 1ns/1ps
module cct_ext_mem
(
   // clock
   input wire logic hclk,
   // bus from the device
   input wire logic [15:0] ext_addr,
   input wire logic [7:0] ext_dout,
   input wire logic ext_doe,
   input wire logic ext_rd_n,
   input wire logic ext_wr_n,
   // answer and observations
   output logic [7:0] ext_din,
   output logic [4:0] strobe_w,
   output logic [15:0] last_addr
);
   logic [7:0] mem [0:65535];
   logic [7:0] held = 8'h00;
   logic [4:0] cnt = 5'h00;
   // sram takes the byte while write is low; strobe width counted in clocks
   always @(posedge hclk)
   begin
      if (!ext_wr_n)
         mem[ext_addr] <= ext_dout;
      if (!ext_rd_n)
         held <= mem[ext_addr];
      if (!ext_rd_n || !ext_wr_n)
      begin
         cnt <= cnt + 5'h01;
         last_addr <= ext_addr;
      end
      else if (cnt != 5'h00)
      begin
         strobe_w <= cnt;
         cnt <= 5'h00;
      end
   end
   // released bus shows the inverse of the last byte, so a late sample cannot match
   always_comb
      ext_din = !ext_rd_n ? mem[ext_addr] : ~held;
endmodule // cct_ext_mem

// file: tb/cct_core_tb_top.sv
`timescale 1ns/1ps
module cct_core_tb_top;
   import cct_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2, instr_cycles = 3'h1;
   logic instr_start = 0, move_start = 0, move_write = 0, move_indirect = 0, sel_inc = 0;
   logic [7:0] indirect_work_register = 0, port2_latch = 0, move_wdata = 0, move_rdata, ext_dout, ext_din;
   logic [3:0] state_onehot;
   logic fetch_strobe, instr_done, busy, ext_doe, ext_rd_n, ext_wr_n;
   logic [15:0] ext_addr, last_addr;
   logic [4:0] strobe_w;
   int n_errors = 0, n_checks = 0;
   assign hready = hreadyout;
   cct_core uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
      .hreadyout, .hresp, .instr_cycles, .instr_start, .move_start, .move_write, .move_indirect,
      .indirect_work_register, .port2_latch, .move_wdata, .sel_inc, .state_onehot, .fetch_strobe,
      .instr_done, .busy, .move_rdata, .ext_addr, .ext_dout, .ext_doe, .ext_din, .ext_rd_n, .ext_wr_n);
   cct_ext_mem mem_i (.hclk, .ext_addr, .ext_dout, .ext_doe, .ext_rd_n, .ext_wr_n, .ext_din, .strobe_w,
      .last_addr);
   // 200 mhz clock
   initial
      forever #2.5 hclk = ~hclk;
   task final_report;
      $display("errors %0d checks %0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // single ahb-lite word transfer, entered just after a rising edge
   task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {20'h00000, a};
      hwrite <= w;
      htrans <= 2'h2;
      // address phase holds until hready is seen high at a rising edge
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      // data phase ends, and read data is taken, at the next edge with hready high
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   // start held high: gap between two completions is one whole operation
   task run(input logic [31:0] exp, input logic [31:0] expf);
      logic [31:0] n;
      logic [31:0] nf;
      do @(negedge hclk); while (instr_done !== 1'b1);
      n = 0;
      nf = 0;
      do
      begin
         @(negedge hclk);
         n++;
         if (fetch_strobe === 1'b1)
            nf++;
      end
      while (instr_done !== 1'b1);
      chk(n, exp);
      chk(nf, expf);
      @(posedge hclk);
   endtask
   task mv(input logic w, input logic ind, input logic [7:0] d, input logic [31:0] cyc, input logic [4:0] sw);
      move_write <= w;
      move_indirect <= ind;
      move_wdata <= d;
      move_start <= 1'b1;
      run(cyc, 1);
      chk(strobe_w, sw);
      move_start <= 1'b0;
      @(posedge hclk);
   endtask
   initial
   begin
      repeat (4) @(posedge hclk);
      chk(state_onehot, ST_ONE);
      chk(busy, 0);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(0, SEL_ADDR, 0);
      chk(r, 0);
      chk({hreadyout, hresp}, 2'b10);
      ahb(0, CLK_CTRL_ADDR, 0);
      chk(r, 1);
      ahb(1, 12'h300, 32'h5a);
      ahb(0, 12'h300, 0);
      chk(r, 0);
      // state order over two machine cycles
      do @(negedge hclk); while (state_onehot !== ST_FOUR);
      for (int i = 0; i < 8; i++)
      begin
         @(negedge hclk);
         chk(state_onehot, 4'h1 << (i % 4));
      end
      @(posedge hclk);
      for (int c = 1; c <= 5; c++)
      begin
         instr_cycles <= c[2:0];
         instr_start <= 1'b1;
         run(4 * c, c);
      end
      instr_start <= 1'b0;
      ahb(1, DPTR0_ADDR, 32'h1234);
      ahb(1, SECONDARY_DATA_POINTER_ADDR, 32'habcd);
      mv(1, 0, 8'h5a, 12, 4);
      chk(last_addr, 16'h1234);
      sel_inc <= 1'b1;
      @(posedge hclk);
      sel_inc <= 1'b0;
      ahb(0, SEL_ADDR, 0);
      chk(r, 1);
      mv(1, 0, 8'ha5, 12, 4);
      chk(last_addr, 16'habcd);
      ahb(1, SEL_ADDR, 32'hff);
      ahb(0, SEL_ADDR, 0);
      chk(r, 1);
      indirect_work_register <= 8'h34;
      port2_latch <= 8'h12;
      mv(0, 1, 0, 12, 4);
      chk(last_addr, 16'h1234);
      chk(move_rdata, 8'h5a);
      // every stretch setting on a pointer read
      for (int s = 0; s < 8; s++)
      begin
         ahb(1, CLK_CTRL_ADDR, s);
         mv(0, 0, 0, 4 * (2 + s), (s == 0) ? 5'h02 : 5'(4 * s));
         chk(move_rdata, 8'ha5);
      end
      final_report;
   end
   // watchdog well beyond the few hundred clocks the run needs
   initial
   begin
      #100000;
      n_errors++;
      final_report;
   end
endmodule // cct_core_tb_top
